// ### hdl/ssp_pkg.sv
package ssp_pkg;
  // =====================================================
  // Register addresses and control reset value
  localparam logic [4:0] ADDR_STEP_CURRENT = 5'h01;
  localparam logic [4:0] ADDR_MOTION_PWM   = 5'h02;
  localparam logic [4:0] ADDR_ENABLE_SLEEP = 5'h03;
  localparam logic [4:0] ADDR_STATUS0      = 5'h04;
  localparam logic [4:0] ADDR_STATUS1      = 5'h05;
  localparam logic [4:0] ADDR_STATUS2      = 5'h06;
  localparam logic [4:0] ADDR_STATUS3      = 5'h07;
  localparam logic [7:0] CTRL_RESET        = 8'h00;
  // =====================================================
  // Commands and framing
  localparam logic [2:0] CMD_READ          = 3'h0;
  localparam logic [2:0] CMD_WRITE         = 3'h4;
  localparam logic [4:0] WRITE_BITS        = 5'h10;
  localparam logic [2:0] LAST_BIT          = 3'h7;
  // =====================================================
  // Field positions
  localparam int STEP_RES_HI  = 7;
  localparam int STEP_RES_LO  = 5;
  localparam int CUR_HI       = 4;
  localparam int CUR_LO       = 0;
  localparam int DIRINV_BIT   = 7;
  localparam int STEP_EDGE_BIT = 6;
  localparam int PWM_DBL_BIT  = 3;
  localparam int PWM_JIT_BIT  = 2;
  localparam int SLOPE_HI     = 1;
  localparam int SLOPE_LO     = 0;
  localparam int DRV_EN_BIT   = 7;
  localparam int SLEEP_BIT    = 6;
  localparam int LA_GAIN_BIT  = 5;
  localparam int LA_TRANS_BIT = 4;
  localparam int PAR_BIT      = 7;
  // =====================================================
  // Step resolution codes
  typedef enum logic [2:0] {
    SSP_RES_32   = 3'b000,
    SSP_RES_16   = 3'b001,
    SSP_RES_8    = 3'b010,
    SSP_RES_4    = 3'b011,
    SSP_HALF_CMP = 3'b100,
    SSP_HALF_UNC = 3'b101,
    SSP_FULL     = 3'b110,
    SSP_RES_NA   = 3'b111
  } ssp_res_e;
  // Slope codes
  typedef enum logic [1:0] {
    SSP_SLOPE_VFAST = 2'b00,
    SSP_SLOPE_FAST  = 2'b01,
    SSP_SLOPE_SLOW  = 2'b10,
    SSP_SLOPE_VSLOW = 2'b11
  } ssp_slope_e;
endpackage

// ### hdl/ssp_spi_regs.sv
`timescale 1ns/100ps
module ssp_spi_regs (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // SPI pins
  input  wire logic       spi_clk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       serial_in_i,
  output logic            spi_do_o,
  output logic            spi_do_oe_n_o,
  // Status sources from the core
  input  wire logic [6:0] status0_i,
  input  wire logic [6:0] status1_set_i,
  input  wire logic [6:0] status2_set_i,
  input  wire logic [6:0] step_position_i,
  // Motion inputs
  input  wire logic       dir_i,
  input  wire logic       step_input_i,
  // Control outputs
  output logic [2:0]      step_resolution_o,
  output logic [4:0]      current_amplitude_index_o,
  output logic            clockwise_o,
  output logic            step_pulse_o,
  output logic            pwm_double_o,
  output logic            pwm_jitter_o,
  output logic [1:0]      slope_select_o,
  output logic            driver_enable_o,
  output logic            sleep_o,
  output logic            load_angle_gain_quarter_o,
  output logic            load_angle_output_transparent_o,
  output logic            error_n_o
);

  // =====================================================
  // Pin synchronisers
  // Three stages; a change counts when stages two and three agree
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [2:0] din_s;
  logic [2:0] dir_s;
  logic [2:0] step_s;
  logic       sclk_q;
  logic       cs_q;
  logic       din_q;
  logic       step_q;

  // Sample all pins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      din_s  <= 3'h0;
      dir_s  <= 3'h0;
      step_s <= 3'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], spi_clk_i};
      cs_s   <= {cs_s[1:0], spi_cs_n_i};
      din_s  <= {din_s[1:0], serial_in_i};
      dir_s  <= {dir_s[1:0], dir_i};
      step_s <= {step_s[1:0], step_input_i};
    end
  end

  // Filtered levels follow only when stages agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      din_q  <= 1'b0;
      step_q <= 1'b0;
    end else begin
      if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
      if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
      if (din_s[1] == din_s[2]) din_q <= din_s[2];
      if (step_s[1] == step_s[2]) step_q <= step_s[2];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic step_rise;
  logic step_fall;
  assign sclk_rise = !cs_q && !sclk_q && (sclk_s[1] == sclk_s[2]) && sclk_s[2];
  assign sclk_fall = !cs_q && sclk_q && (sclk_s[1] == sclk_s[2]) && !sclk_s[2];
  assign cs_rise   = !cs_q && (cs_s[1] == cs_s[2]) && cs_s[2];
  assign step_rise = !step_q && (step_s[1] == step_s[2]) && step_s[2];
  assign step_fall = step_q && (step_s[1] == step_s[2]) && !step_s[2];

  // =====================================================
  // Register bank
  logic [7:0] step_current_control;
  logic [7:0] motion_pwm_control;
  logic [7:0] enable_sleep_angle_control;
  logic [6:0] status1;
  logic [6:0] status2;
  logic [6:0] status0_snap;
  logic [6:0] position_snap;

  // Local copies of the map, declared before the read mux uses them
  localparam logic [4:0] ADDR_STEP_CURRENT_L = ssp_pkg::ADDR_STEP_CURRENT;
  localparam logic [4:0] ADDR_MOTION_PWM_L   = ssp_pkg::ADDR_MOTION_PWM;
  localparam logic [4:0] ADDR_ENABLE_SLEEP_L = ssp_pkg::ADDR_ENABLE_SLEEP;
  localparam logic [4:0] ADDR_STATUS0_L      = ssp_pkg::ADDR_STATUS0;
  localparam logic [4:0] ADDR_STATUS1_L      = ssp_pkg::ADDR_STATUS1;
  localparam logic [4:0] ADDR_STATUS2_L      = ssp_pkg::ADDR_STATUS2;
  localparam logic [4:0] ADDR_STATUS3_L      = ssp_pkg::ADDR_STATUS3;

  // Parity of seven data bits
  function automatic logic [7:0] with_parity(input logic [6:0] d);
    with_parity = {^d, d};
  endfunction

  // Read mux; unmapped addresses return zero
  function automatic logic [7:0] read_reg(input logic [4:0] a);
    case (a)
      ADDR_STEP_CURRENT_L: read_reg = step_current_control;
      ADDR_MOTION_PWM_L:   read_reg = motion_pwm_control;
      ADDR_ENABLE_SLEEP_L: read_reg = enable_sleep_angle_control;
      ADDR_STATUS0_L:      read_reg = with_parity(status0_snap);
      ADDR_STATUS1_L:      read_reg = with_parity(status1);
      ADDR_STATUS2_L:      read_reg = with_parity(status2);
      ADDR_STATUS3_L:      read_reg = with_parity(position_snap);
      default:             read_reg = 8'h00;
    endcase
  endfunction

  // =====================================================
  // Serial engine
  logic [2:0] bit_cnt;
  logic [4:0] frame_bits;
  logic [6:0] shift_in;
  logic [7:0] shift_out;
  logic [4:0] last_addr;
  logic [7:0] first_byte;
  logic [7:0] wr_data;
  logic       clr_s1;
  logic       clr_s2;
  logic [7:0] rx_byte;
  logic       byte_done;

  assign rx_byte   = {shift_in, din_q};
  assign byte_done = sclk_fall && (bit_cnt == ssp_pkg::LAST_BIT);

  // Frame counting and input shifting on rising edges, bit counting on falling edges
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cs_q) begin
      bit_cnt    <= 3'h0;
      frame_bits <= 5'h00;
      shift_in   <= 7'h00;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[5:0], din_q};
      if (frame_bits != 5'h1F) frame_bits <= frame_bits + 5'h01;
    end else if (sclk_fall) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Latch the received bytes at the eighth falling edge
  logic [7:0] held_byte;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      held_byte  <= 8'h00;
      first_byte <= 8'h00;
      wr_data    <= 8'h00;
    end else if (sclk_rise && bit_cnt == ssp_pkg::LAST_BIT) begin
      held_byte <= rx_byte;
    end else if (byte_done) begin
      if (frame_bits == 5'h08) first_byte <= held_byte;
      if (frame_bits == ssp_pkg::WRITE_BITS) wr_data <= held_byte;
    end
  end

  // Output shifter; last address holds across frames
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift_out <= 8'h00;
      last_addr <= 5'h00;
      clr_s1    <= 1'b0;
      clr_s2    <= 1'b0;
    end else if (byte_done) begin
      if (frame_bits == ssp_pkg::WRITE_BITS && first_byte[7:5] == ssp_pkg::CMD_WRITE) begin
        // Data byte of a write is no command: repeat the old content, keep the address
        shift_out <= read_reg(last_addr);
      end else begin
        // Every other byte is a command: load its register and adopt its address
        shift_out <= read_reg(held_byte[4:0]);
        last_addr <= held_byte[4:0];
        clr_s1    <= clr_s1 || (held_byte[7:5] == ssp_pkg::CMD_READ && held_byte[4:0] == ADDR_STATUS1_L);
        clr_s2    <= clr_s2 || (held_byte[7:5] == ssp_pkg::CMD_READ && held_byte[4:0] == ADDR_STATUS2_L);
      end
    end else if (sclk_fall) begin
      shift_out <= {shift_out[6:0], 1'b0};
    end else if (cs_q) begin
      clr_s1 <= 1'b0;
      clr_s2 <= 1'b0;
    end
  end

  // Drive data only while selected; open drain style release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      spi_do_o      <= 1'b1;
      spi_do_oe_n_o <= 1'b1;
    end else begin
      spi_do_o      <= shift_out[7];
      spi_do_oe_n_o <= cs_q;
    end
  end

  // =====================================================
  // Control register commit at deselect
  // Write lands only after the old value already left the shifter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      step_current_control       <= ssp_pkg::CTRL_RESET;
      motion_pwm_control         <= ssp_pkg::CTRL_RESET;
      enable_sleep_angle_control <= ssp_pkg::CTRL_RESET;
    end else if (cs_rise && frame_bits == ssp_pkg::WRITE_BITS &&
                 first_byte[7:5] == ssp_pkg::CMD_WRITE) begin
      case (first_byte[4:0])
        ADDR_STEP_CURRENT_L: step_current_control       <= wr_data;
        ADDR_MOTION_PWM_L:   motion_pwm_control         <= wr_data;
        ADDR_ENABLE_SLEEP_L: enable_sleep_angle_control <= wr_data;
        default:             ;
      endcase
    end
  end

  // =====================================================
  // Status latching, frozen during transfers
  // A set present only while selected is lost; the read clear is applied before new sets
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status1       <= 7'h00;
      status2       <= 7'h00;
      status0_snap  <= 7'h00;
      position_snap <= 7'h00;
      error_n_o     <= 1'b1;
    end else if (cs_q) begin
      status1       <= (clr_s1 ? 7'h00 : status1) | status1_set_i;
      status2       <= (clr_s2 ? 7'h00 : status2) | status2_set_i;
      status0_snap  <= status0_i;
      position_snap <= step_position_i;
      error_n_o     <= !(|status0_i[5:0] || |((clr_s1 ? 7'h00 : status1) | status1_set_i)
                         || |((clr_s2 ? 7'h00 : status2) | status2_set_i));
    end
  end

  // =====================================================
  // Decoded control fields
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      step_pulse_o <= 1'b0;
      clockwise_o  <= 1'b1;
    end else begin
      // Step and direction ignored in sleep
      step_pulse_o <= !enable_sleep_angle_control[ssp_pkg::SLEEP_BIT] &&
                      (motion_pwm_control[ssp_pkg::STEP_EDGE_BIT] ? step_fall : step_rise);
      if (dir_s[1] == dir_s[2] && !enable_sleep_angle_control[ssp_pkg::SLEEP_BIT])
        clockwise_o <= (dir_s[2] == motion_pwm_control[ssp_pkg::DIRINV_BIT]);
    end
  end

  assign step_resolution_o = step_current_control[ssp_pkg::STEP_RES_HI:ssp_pkg::STEP_RES_LO];
  assign current_amplitude_index_o = step_current_control[ssp_pkg::CUR_HI:ssp_pkg::CUR_LO];
  assign pwm_double_o = motion_pwm_control[ssp_pkg::PWM_DBL_BIT];
  assign pwm_jitter_o = motion_pwm_control[ssp_pkg::PWM_JIT_BIT];
  assign slope_select_o = motion_pwm_control[ssp_pkg::SLOPE_HI:ssp_pkg::SLOPE_LO];
  assign driver_enable_o = enable_sleep_angle_control[ssp_pkg::DRV_EN_BIT] &&
                           !enable_sleep_angle_control[ssp_pkg::SLEEP_BIT];
  assign sleep_o = enable_sleep_angle_control[ssp_pkg::SLEEP_BIT];
  assign load_angle_gain_quarter_o = enable_sleep_angle_control[ssp_pkg::LA_GAIN_BIT];
  assign load_angle_output_transparent_o = enable_sleep_angle_control[ssp_pkg::LA_TRANS_BIT];

endmodule

// ### testbench/ssp_spi_master.sv
`timescale 1ns/100ps
// ====================
// Mode 0 SPI master, MSB first, half period of 8 clocks
module ssp_spi_master (
  // Clock
  input  wire logic clk_i,
  // SPI pins
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  // Idle: clock low, deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One frame of n bits; lengths other than 16 for discarded writes and the 24-bit status read
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    mosi_o = tx[n-1];
    for (int i = n - 1; i >= 0; i--) begin
      repeat (8) @(negedge clk_i);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      repeat (8) @(negedge clk_i);
      sclk_o = 1'b0;
      if (i > 0) mosi_o = tx[i-1];
    end
    repeat (8) @(negedge clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line shows no stale value
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// ### testbench/ssp_spi_regs_asserts.sv
`timescale 1ns/100ps
// ====================
// Port checker for the SPI register port
module ssp_spi_regs_asserts (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // Watched pins
  input wire logic       spi_cs_n_i,
  input wire logic       spi_do_oe_n_o,
  input wire logic       dir_i,
  input wire logic       step_input_i,
  input wire logic       clockwise_o,
  input wire logic       step_pulse_o,
  input wire logic       driver_enable_o,
  input wire logic       sleep_o,
  input wire logic       error_n_o,
  input wire logic [2:0] step_resolution_o,
  input wire logic [1:0] slope_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Select edges held past the three-flop synchroniser
  sequence s_sel;
    $fell(spi_cs_n_i) ##1 !spi_cs_n_i[*6];
  endsequence
  sequence s_desel;
    $rose(spi_cs_n_i) ##1 spi_cs_n_i[*6];
  endsequence
  // Saturating cycle counts of each select level
  logic [3:0] hi_cnt;
  logic [3:0] lo_cnt;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !spi_cs_n_i) hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || spi_cs_n_i) lo_cnt <= 4'h0;
    else if (lo_cnt != 4'hF) lo_cnt <= lo_cnt + 4'h1;
  end
  AST_DO_DRIVEN: assert property (s_sel |-> !spi_do_oe_n_o)
    else $error("data out not driven while selected");
  AST_DO_RELEASED: assert property (s_desel |-> spi_do_oe_n_o)
    else $error("data out still driven while deselected");
  AST_REG_LOW: assert property (lo_cnt > 4'h6 |-> $stable(step_resolution_o) && $stable(slope_select_o) && $stable(sleep_o))
    else $error("control changed during a transfer");
  AST_REG_HIGH: assert property (hi_cnt > 4'hC |-> $stable(step_resolution_o) && $stable(slope_select_o))
    else $error("control changed long after select rose");
  AST_ERR_HOLD: assert property (lo_cnt > 4'h6 |-> $stable(error_n_o))
    else $error("error pin changed while selected");
  AST_DIR: assert property (hi_cnt > 4'hC && !sleep_o && $changed(dir_i) |-> ##[2:8] $changed(clockwise_o))
    else $error("direction input ignored");
  AST_EN_SLEEP: assert property (driver_enable_o |-> !sleep_o)
    else $error("driver enabled in sleep");
  AST_PULSE_ONE: assert property (step_pulse_o |=> !step_pulse_o)
    else $error("step pulse longer than one cycle");
  AST_PULSE_CAUSE: assert property (step_pulse_o |-> $past(step_input_i, 1) != $past(step_input_i, 8))
    else $error("step pulse without input edge");
endmodule
bind ssp_spi_regs ssp_spi_regs_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_do_oe_n_o(spi_do_oe_n_o), .dir_i(dir_i), .step_input_i(step_input_i), .clockwise_o(clockwise_o),
  .step_pulse_o(step_pulse_o), .driver_enable_o(driver_enable_o), .sleep_o(sleep_o), .error_n_o(error_n_o),
  .step_resolution_o(step_resolution_o), .slope_select_o(slope_select_o));

// ### testbench/testbench.sv
`timescale 1ns/100ps
// ====================
// Self-checking bench for the SPI register port
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        dir_i = 1'b0;
  logic        step_in = 1'b0;
  logic [6:0]  st0 = 7'h00, st1 = 7'h00, st2 = 7'h00, pos = 7'h00;
  logic        sclk, cs_n, mosi, do_pin, do_oe_n, cw, pulse, pdbl, pjit, en, slp, lag, lat, err_n;
  logic [2:0]  res;
  logic [4:0]  cur;
  logic [1:0]  slope;
  logic [7:0]  regs [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  seed = 8'h1B;
  logic [7:0]  d, old;
  logic [6:0]  v0, v1, v2, v3;
  logic [31:0] r;
  int          mismatches = 0;
  int          checks_done = 0;
  wire         do_line = do_oe_n ? 1'b1 : do_pin; // Pull-up when released
  always #2 clk_i = ~clk_i;
  ssp_spi_master m (.clk_i(clk_i), .miso_i(do_line), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
  ssp_spi_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_clk_i(sclk), .spi_cs_n_i(cs_n), .serial_in_i(mosi),
    .spi_do_o(do_pin), .spi_do_oe_n_o(do_oe_n), .status0_i(st0), .status1_set_i(st1), .status2_set_i(st2),
    .step_position_i(pos), .dir_i(dir_i), .step_input_i(step_in), .step_resolution_o(res),
    .current_amplitude_index_o(cur), .clockwise_o(cw), .step_pulse_o(pulse), .pwm_double_o(pdbl),
    .pwm_jitter_o(pjit), .slope_select_o(slope), .driver_enable_o(en), .sleep_o(slp),
    .load_angle_gain_quarter_o(lag), .load_angle_output_transparent_o(lat), .error_n_o(err_n));
  // Eight-bit LFSR, fixed start
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  // Status byte: odd count of ones sets the top bit
  function automatic logic [7:0] par(input logic [6:0] v);
    return {^v, v};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    m.xfer(16, {16'h0, ssp_pkg::CMD_READ, a, 8'h00}, r);
    chk(r[7:0], e);
  endtask
  // Write returns the old content in its data byte
  task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [7:0] o);
    m.xfer(16, {16'h0, ssp_pkg::CMD_WRITE, a, v}, r);
    chk(r[7:0], o);
  endtask
  // Control outputs against the model copy
  task automatic fields();
    chk({res, cur}, regs[1]);
    chk({4'h0, pdbl, pjit, slope}, {4'h0, regs[2][3:0]});
    chk({en, slp, lag, lat, 4'h0}, {regs[3][7] & ~regs[3][6], regs[3][6:4], 4'h0});
    if (!regs[3][6]) chk({7'h0, cw}, {7'h0, dir_i ~^ regs[2][7]});
  endtask
  // Toggle the step pin; one pulse only on the selected edge and when awake
  task automatic step_chk();
    int p;
    p = 0;
    step_in = ~step_in;
    repeat (12) begin
      @(negedge clk_i);
      p += pulse;
    end
    chk(8'(p), {7'h0, !regs[3][6] && (step_in ^ regs[2][6])});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    for (int a = 1; a < 4; a++) rd(5'(a), 8'h00);
    // Random writes; every step code forced once, every slope code twice
    for (int n = 0; n < 24; n++) begin
      d = rnd();
      if (n % 3 == 0) d[7:5] = 3'(n / 3);
      if (n % 3 == 1) d[1:0] = 2'(n / 3);
      repeat (12) @(negedge clk_i);
      dir_i = d[4] ^ seed[0];
      wr(5'(n % 3 + 1), d, regs[n%3+1]);
      regs[n%3+1] = d;
      fields();
      step_chk();
      step_chk();
    end
    // Read back after write: old value once more, then new
    d = rnd();
    old = regs[2];
    wr(5'h02, d, old);
    regs[2] = d;
    m.xfer(16, {16'h0, ssp_pkg::CMD_READ, 5'h02, 8'h00}, r);
    chk(r[15:8], old);
    chk(r[7:0], d);
    // Short and long writes, and a write to a status address, are dropped
    m.xfer(15, {16'h0, ssp_pkg::CMD_WRITE, 5'h01, ~regs[1]} >> 1, r);
    m.xfer(17, {15'h0, ssp_pkg::CMD_WRITE, 5'h01, ~regs[1], 1'b1}, r);
    fields();
    wr(5'h04, rnd(), 8'h00);
    fields();
    // Status bytes, latched errors and clear on read
    v0 = rnd() & 7'h6C;
    v1 = rnd() & 7'h78 | 7'h08;
    v2 = rnd() & 7'h7C | 7'h04;
    v3 = 7'(rnd());
    st0 = v0;
    pos = v3;
    st1 = v1;
    st2 = v2;
    repeat (8) @(negedge clk_i);
    st1 = 7'h00;
    st2 = 7'h00;
    repeat (8) @(negedge clk_i);
    chk({7'h0, err_n}, 8'h00);
    rd(5'h04, par(v0));
    st0 = 7'h00;
    rd(5'h07, par(v3));
    m.xfer(24, {8'h0, ssp_pkg::CMD_READ, 5'h05, ssp_pkg::CMD_READ, 5'h06, 8'h00}, r);
    chk(r[15:8], par(v1));
    chk(r[7:0], par(v2));
    repeat (8) @(negedge clk_i);
    chk({7'h0, err_n}, 8'h01);
    rd(5'h05, 8'h00);
    rd(5'h06, 8'h00);
    tally_and_finish();
  end
endmodule
